/* rtl/vr_fault_supervisor_map.vh */
// register offsets, field positions, reset values and timing counts
// assumes a 50 MHz system clock and 12.5 mV per voltage code step
`ifndef VR_FAULT_SUPERVISOR_MAP_VH
`define VR_FAULT_SUPERVISOR_MAP_VH
// ****************************************
// register map (byte addresses)
// ****************************************
`define VFS_ADDR_STATUS 4'h0
`define VFS_ADDR_EVENT 4'h4
`define VFS_ADDR_MASK 4'h8
`define VFS_EVENT_W 6
`define VFS_EVENT_RST 6'h00
`define VFS_MASK_RST 6'h00
`define VFS_EV_OV_TRIP 0
`define VFS_EV_OV_LATCH 1
`define VFS_EV_OC_LATCH 2
`define VFS_EV_UV 3
`define VFS_EV_LOCKOUT 4
`define VFS_EV_EXT_LOW 5
// ****************************************
// states and voltage levels
// ****************************************
`define VFS_ST_OFF 2'h0
`define VFS_ST_SOFT 2'h1
`define VFS_ST_RUN 2'h2
`define VFS_CODE_OFF 7'h7c
`define VFS_LEVEL_MAX 7'h7c
// ****************************************
// timing
// ****************************************
`define VFS_CLK_MHZ 50
`define VFS_STEP_UV 12500
`define VFS_SS_RATE_UV_PER_US 800
`define VFS_SLEW_RATE_UV_PER_US 3250
`define VFS_SS_STEP_CYC (`VFS_STEP_UV * `VFS_CLK_MHZ / `VFS_SS_RATE_UV_PER_US)
`define VFS_SLEW_STEP_CYC (`VFS_STEP_UV * `VFS_CLK_MHZ / `VFS_SLEW_RATE_UV_PER_US)
`define VFS_OC_DELAY_MS 50
`define VFS_OC_DELAY_CYC (`VFS_OC_DELAY_MS * 1000 * `VFS_CLK_MHZ)
`define VFS_PG_HOLD_US 500
`define VFS_PG_HOLD_CYC (`VFS_PG_HOLD_US * `VFS_CLK_MHZ)
`define VFS_OV_DEC_PWM 4096
`define VFS_OV_LATCH_COUNT 16
`endif

/* rtl/vr_fault_supervisor.v */
// fault supervision and output sequencing for a multiphase buck controller
// assumes comparator results, straps and pwm oscillator arrive as async pins
//
// Design decisions made here: the address map and register access over Avalon-MM.
`include "vr_fault_supervisor_map.vh"

// Overview of operation
// - overvoltage: power good low, pwm low
// - count trips, latch at threshold count
// - overvoltage latch cleared by reset/enable cycle
// - below threshold, resume when overvoltage clears
// - decrement counter every 4096 pwm cycles
// - undervoltage holds power good low only
// - soft-start targets to startup code
// - new code after power ok: slew
// - delayed overcurrent latches after 50 ms
// - immediate overcurrent latches at once
// - supply lockout shuts down, samples phases
// - enable low shuts down, keeps phases
// - core enable low externally: pull-up, 0V
// - northbridge enable low externally: pull-up, 0V
// - overcurrent latch cleared by enable/supply cycle
// - northbridge overcurrent pulls its enable low
// - power ok loss: back to startup code
module vr_fault_supervisor #(
  parameter OC_DELAY_CYCLES   = `VFS_OC_DELAY_CYC,
  parameter PG_HOLD_CYCLES    = `VFS_PG_HOLD_CYC,
  parameter OV_DEC_PWM_CYCLES = `VFS_OV_DEC_PWM,
  parameter OV_LATCH_COUNT    = `VFS_OV_LATCH_COUNT
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  output reg         irq,
  input  wire        ov_cmp_in,
  input  wire        uv_cmp_in,
  input  wire        oc_delayed_in,
  input  wire        oc_immediate_in,
  input  wire        nb_oc_in,
  input  wire        supply5_ok_in,
  input  wire        supply12_ok_in,
  input  wire        enable_in,
  input  wire        cpu_power_ok_in,
  input  wire        serial_id_mode,
  input  wire [1:0]  phase_sel_in,
  input  wire [6:0]  startup_voltage_code,
  input  wire [6:0]  vid_code_in,
  input  wire        pwm_osc_in,
  input  wire [3:0]  pwm_in,
  input  wire        nb_pwm_in,
  output reg  [3:0]  pwm_out,
  output reg  [3:0]  pwm_oe,
  output reg         nb_pwm_out,
  output reg         nb_pwm_oe,
  input  wire        driver_enable_in,
  output reg         driver_enable_out,
  output reg         driver_enable_oe,
  output reg         driver_enable_pullup,
  input  wire        nb_driver_enable_in,
  output reg         nb_driver_enable_out,
  output reg         nb_driver_enable_oe,
  output reg         nb_driver_enable_pullup,
  output reg         power_good_out,
  output reg  [6:0]  core_level,
  output reg  [6:0]  nb_level,
  output reg  [1:0]  phase_count
);

  // ****************************************
  // input synchronisers
  // ****************************************
  reg  [31:0] sync1;
  reg  [31:0] sync2;
  wire [31:0] raw = {3'h0, nb_driver_enable_in, driver_enable_in, pwm_osc_in, vid_code_in, startup_voltage_code,
                     phase_sel_in, serial_id_mode, cpu_power_ok_in, enable_in, supply12_ok_in, supply5_ok_in,
                     nb_oc_in, oc_immediate_in, oc_delayed_in, uv_cmp_in, ov_cmp_in};
  wire ov_cmp = sync2[0];
  wire uv_cmp = sync2[1];
  wire oc_del = sync2[2];
  wire oc_imm = sync2[3];
  wire nb_oc = sync2[4];
  wire lockout = !(sync2[5] & sync2[6]);
  wire en = sync2[7];
  wire cpu_ok = sync2[8];
  wire serial = sync2[9];
  wire [1:0] phase_sel = sync2[11:10];
  wire [6:0] boot_code = sync2[18:12];
  wire [6:0] vid_code = sync2[25:19];
  wire pwm_osc = sync2[26];
  wire drv_sense = sync2[27];
  wire nb_drv_sense = sync2[28];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 32'h00000000;
      sync2 <= 32'h00000000;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  function [6:0] code_level;
    input [6:0] c;
    begin
      code_level = (c >= `VFS_CODE_OFF) ? 7'h00 : (`VFS_LEVEL_MAX - c);
    end
  endfunction

  // ****************************************
  // state and protection
  // ****************************************
  reg [1:0]  state;
  reg [1:0]  settle;
  reg [4:0]  ov_cnt;
  reg        ov_latched;
  reg        oc_latched;
  reg        ov_q;
  reg        uv_q;
  reg        osc_q;
  reg        ext_q;
  reg        lock_q;
  reg [12:0] dec_cnt;
  reg [21:0] oc_cnt;
  reg [14:0] pg_hold;
  reg [9:0]  step_cnt;
  reg [6:0]  boot_lvl;
  reg [6:0]  vid_prev;
  reg        vid_taken;
  reg [5:0]  event_flags;
  reg [5:0]  irq_mask;

  wire shut = lockout | !en | oc_latched;
  wire active = (state != `VFS_ST_OFF);
  wire armed = active & (settle == 2'h3);
  wire drv_low = armed & !drv_sense;
  wire nb_low = armed & !nb_drv_sense;
  wire ext_any = drv_low | nb_low;
  wire ov = active & ov_cmp;
  wire ov_trip = ov & !ov_q & !ov_latched;
  wire ov_to_latch = ov_trip & (ov_cnt == OV_LATCH_COUNT - 1);
  wire osc_edge = pwm_osc & !osc_q;
  wire dec_tick = osc_edge & (dec_cnt == OV_DEC_PWM_CYCLES - 1);
  wire oc_to_latch = active & (oc_imm | nb_oc | (oc_cnt == OC_DELAY_CYCLES - 1));
  wire [6:0] run_lvl = vid_taken ? code_level(vid_code) : boot_lvl;
  wire [6:0] goal_lvl = (state == `VFS_ST_SOFT) ? boot_lvl : run_lvl;
  wire [6:0] core_goal = drv_low ? 7'h00 : goal_lvl;
  wire [6:0] nb_goal = (nb_low | !serial) ? 7'h00 : goal_lvl;
  localparam SS_STEP   = `VFS_SS_STEP_CYC;
  localparam SLEW_STEP = `VFS_SLEW_STEP_CYC;
  wire [9:0] step_len = (state == `VFS_ST_SOFT) ? SS_STEP[9:0] : SLEW_STEP[9:0];
  wire step = (step_cnt >= step_len - 10'h001);
  wire [3:0] used = (phase_count == 2'h0) ? 4'h3 : (phase_count == 2'h1) ? 4'h7 : 4'hf;
  wire [5:0] ev_set = {ext_any & !ext_q, lockout & !lock_q, active & uv_cmp & !uv_q,
                       oc_to_latch & !oc_latched, ov_to_latch, ov_trip};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= `VFS_ST_OFF;
      settle <= 2'h0;
      ov_cnt <= 5'h00;
      ov_latched <= 1'b0;
      oc_latched <= 1'b0;
      ov_q <= 1'b0;
      uv_q <= 1'b0;
      osc_q <= 1'b0;
      ext_q <= 1'b0;
      lock_q <= 1'b0;
      dec_cnt <= 13'h0000;
      oc_cnt <= 22'h000000;
      pg_hold <= 15'h0000;
      step_cnt <= 10'h000;
      boot_lvl <= 7'h00;
      vid_prev <= 7'h00;
      vid_taken <= 1'b0;
      phase_count <= 2'h3;
      core_level <= 7'h00;
      nb_level <= 7'h00;
    end else begin
      ov_q <= ov;
      uv_q <= active & uv_cmp;
      osc_q <= pwm_osc;
      ext_q <= ext_any;
      lock_q <= lockout;
      vid_prev <= vid_code;
      settle <= !active ? 2'h0 : (settle == 2'h3) ? settle : settle + 2'h1;
      // pwm cycle counter runs free of enable
      if (osc_edge)
        dec_cnt <= dec_tick ? 13'h0000 : dec_cnt + 13'h0001;
      if (lockout)
        phase_count <= phase_sel;
      if (!en | lockout) begin
        ov_cnt <= 5'h00;
        ov_latched <= 1'b0;
        oc_latched <= 1'b0;
      end else begin
        if (ov_trip & !(dec_tick & ov_cnt != 5'h00))
          ov_cnt <= ov_cnt + 5'h01;
        else if (dec_tick & !ov_trip & ov_cnt != 5'h00)
          ov_cnt <= ov_cnt - 5'h01;
        if (ov_to_latch)
          ov_latched <= 1'b1;
        if (oc_to_latch)
          oc_latched <= 1'b1;
      end
      if (active & oc_del & !oc_imm)
        oc_cnt <= oc_cnt + 22'h000001;
      else
        oc_cnt <= 22'h000000;
      if (ov)
        pg_hold <= PG_HOLD_CYCLES[14:0];
      else if (pg_hold != 15'h0000)
        pg_hold <= pg_hold - 15'h0001;
      if (!cpu_ok)
        vid_taken <= 1'b0;
      else if (vid_code != vid_prev)
        vid_taken <= 1'b1;
      step_cnt <= (step | !active) ? 10'h000 : step_cnt + 10'h001;
      case (state)
        `VFS_ST_OFF: begin
          core_level <= 7'h00;
          nb_level <= 7'h00;
          if (!shut) begin
            boot_lvl <= code_level(boot_code);
            state <= `VFS_ST_SOFT;
          end
        end
        `VFS_ST_SOFT: begin
          if (!ext_any & core_level == core_goal & nb_level == nb_goal)
            state <= `VFS_ST_RUN;
        end
        `VFS_ST_RUN: begin
          if (ext_q & !ext_any)
            state <= `VFS_ST_SOFT;
        end
        default: state <= `VFS_ST_OFF;
      endcase
      if (active) begin
        if (drv_low)
          core_level <= 7'h00;
        else if (step & core_level < core_goal)
          core_level <= core_level + 7'h01;
        else if (step & core_level > core_goal)
          core_level <= core_level - 7'h01;
        if (nb_low)
          nb_level <= 7'h00;
        else if (step & nb_level < nb_goal)
          nb_level <= nb_level + 7'h01;
        else if (step & nb_level > nb_goal)
          nb_level <= nb_level - 7'h01;
      end
      if (shut)
        state <= `VFS_ST_OFF;
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out <= 4'h0;
      pwm_oe <= 4'h0;
      nb_pwm_out <= 1'b0;
      nb_pwm_oe <= 1'b0;
      driver_enable_out <= 1'b0;
      driver_enable_oe <= 1'b1;
      driver_enable_pullup <= 1'b0;
      nb_driver_enable_out <= 1'b0;
      nb_driver_enable_oe <= 1'b1;
      nb_driver_enable_pullup <= 1'b0;
      power_good_out <= 1'b0;
    end else begin
      driver_enable_out <= 1'b0;
      nb_driver_enable_out <= 1'b0;
      // enables are pulled low only while shut down
      driver_enable_oe <= shut;
      nb_driver_enable_oe <= shut;
      driver_enable_pullup <= drv_low;
      nb_driver_enable_pullup <= nb_low;
      if (shut | !active) begin
        pwm_oe <= 4'h0;
        nb_pwm_oe <= 1'b0;
        pwm_out <= 4'h0;
        nb_pwm_out <= 1'b0;
      end else if (ov | ov_latched) begin
        pwm_oe <= used;
        nb_pwm_oe <= 1'b1;
        pwm_out <= 4'h0;
        nb_pwm_out <= 1'b0;
      end else begin
        pwm_oe <= used;
        nb_pwm_oe <= 1'b1;
        pwm_out <= pwm_in & used;
        nb_pwm_out <= nb_pwm_in;
      end
      power_good_out <= !shut & (state == `VFS_ST_RUN) & !ov & !ov_latched & (pg_hold == 15'h0000) &
                        !uv_cmp & !ext_any;
    end
  end

  // ****************************************
  // avalon slave and interrupt
  // ****************************************
  wire [31:0] status_word = {19'h00000, ov_cnt, phase_count, oc_latched, ov_latched, power_good_out,
                             active, state};
  wire ev_clr = write & !waitrequest & (address == `VFS_ADDR_EVENT);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      event_flags <= `VFS_EVENT_RST;
      irq_mask <= `VFS_MASK_RST;
      irq <= 1'b0;
    end else begin
      waitrequest <= !((read | write) & waitrequest);
      if (read & waitrequest) begin
        case (address)
          `VFS_ADDR_STATUS: readdata <= status_word;
          `VFS_ADDR_EVENT: readdata <= {26'h0000000, event_flags};
          `VFS_ADDR_MASK: readdata <= {26'h0000000, irq_mask};
          default: readdata <= 32'h00000000;
        endcase
      end
      if (write & !waitrequest & (address == `VFS_ADDR_MASK))
        irq_mask <= writedata[5:0];
      // a new event wins over a clear in the same cycle
      event_flags <= (event_flags & ~(ev_clr ? writedata[5:0] : 6'h00)) | ev_set;
      irq <= |(event_flags & irq_mask);
    end
  end

endmodule

/* rtl/README_dummy_never.v */
// holds no logic: the whole supervisor lives in vr_fault_supervisor.v
// assumes nothing of its surroundings

/* tb/vr_driver_stage.sv */
// driver stage model: open-drain enable lines with board pull-ups
// assumes the supervisor raises oe to pull a line low
module vr_driver_stage (
  input  wire logic       driver_enable_oe,
  input  wire logic       nb_driver_enable_oe,
  input  wire logic [1:0] ext_low,
  output wire logic       driver_enable_in,
  output wire logic       nb_driver_enable_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a line is low while any party pulls it, else the pull-up wins
  assign driver_enable_in    = !(driver_enable_oe || ext_low[0]);
  assign nb_driver_enable_in = !(nb_driver_enable_oe || ext_low[1]);
endmodule

/* tb/vr_fault_supervisor_chk.sv */
// checker of the supervisor's fault responses and bus answer
// assumes the top module port names; one clock, async active-low reset
module vr_fault_supervisor_chk (
  input logic       clk,
  input logic       rst_n,
  input logic       read,
  input logic       write,
  input logic       waitrequest,
  input logic       enable_in,
  input logic       supply5_ok_in,
  input logic       supply12_ok_in,
  input logic       ov_cmp_in,
  input logic       uv_cmp_in,
  input logic       oc_immediate_in,
  input logic [3:0] pwm_out,
  input logic [3:0] pwm_oe,
  input logic       nb_pwm_oe,
  input logic       driver_enable_oe,
  input logic       nb_driver_enable_oe,
  input logic       power_good_out,
  input logic [6:0] core_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // fault responses, level steps and bus answer
  // ****************************************
  sequence s_shut;
    pwm_oe == 4'h0 && !nb_pwm_oe && driver_enable_oe && nb_driver_enable_oe && !power_good_out;
  endsequence
  a_ov_pwm_low: assert property (ov_cmp_in [*5] |-> (pwm_out & pwm_oe) == 4'h0 && !power_good_out)
    else $error("pwm not low in overvoltage");
  a_enable_shut: assert property (!enable_in [*5] |-> s_shut)
    else $error("no shutdown with enable low");
  a_lockout_shut: assert property ((!supply5_ok_in || !supply12_ok_in) [*5] |-> s_shut)
    else $error("no shutdown in lockout");
  a_oc_now: assert property (oc_immediate_in [*5] |-> s_shut)
    else $error("no shutdown on overcurrent");
  a_oc_hold: assert property ($fell(oc_immediate_in) && enable_in |-> s_shut [*8])
    else $error("overcurrent latch released");
  a_uv_pg_low: assert property (uv_cmp_in [*5] |-> !power_good_out)
    else $error("power good high in undervoltage");
  a_level_step: assert property (|core_level && |$past(core_level) && $changed(core_level)
    |-> core_level == $past(core_level) + 7'h01 || core_level == $past(core_level) - 7'h01)
    else $error("level moved by more than one step");
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");
endmodule
bind vr_fault_supervisor vr_fault_supervisor_chk u_chk (.*);

/* tb/vr_fault_supervisor_test.sv */
// testbench: bus tasks and fault scenarios for the supervisor
// assumes the design, checker and driver stage model are compiled first
module vr_fault_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, rst_n = 1'h0, read = 1'h0, write = 1'h0, ov_cmp_in = 1'h0, uv_cmp_in = 1'h0;
  logic        oc_delayed_in = 1'h0, oc_immediate_in = 1'h0, nb_oc_in = 1'h0, supply5_ok_in = 1'h0;
  logic        supply12_ok_in = 1'h0, enable_in = 1'h0, cpu_power_ok_in = 1'h0, serial_id_mode = 1'h1;
  logic        pwm_osc_in = 1'h0, nb_pwm_in = 1'h1, waitrequest, irq, nb_pwm_out, nb_pwm_oe, power_good_out;
  logic        driver_enable_in, driver_enable_out, driver_enable_oe, driver_enable_pullup;
  logic        nb_driver_enable_in, nb_driver_enable_out, nb_driver_enable_oe, nb_driver_enable_pullup;
  logic [1:0]  phase_sel_in = 2'h1, ext_low = 2'h0, phase_count;
  logic [3:0]  address = 4'h0, pwm_in = 4'hf, pwm_out, pwm_oe;
  logic [6:0]  startup_voltage_code = 7'h7a, vid_code_in = 7'h7a, core_level, nb_level;
  logic [31:0] writedata = 32'h0, readdata, q;
  int          n_fail = 0, checked = 0, k;
  vr_fault_supervisor #(.OC_DELAY_CYCLES(100), .PG_HOLD_CYCLES(20), .OV_DEC_PWM_CYCLES(8),
    .OV_LATCH_COUNT(4)) u_dut (.*);
  vr_driver_stage u_drv (.*);
  initial begin
    forever #10 clk = ~clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic done(input string nm);
    $display("test %s done, mismatches %0d", nm, n_fail);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    do begin
      @(posedge clk);
      i++;
    end while (waitrequest !== 1'h0 && i < 100);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    if (i >= 100) begin
      n_fail++;
      end_sim;
    end
  endtask
  task automatic wpg;
    int i;
    i = 0;
    while (power_good_out !== 1'h1 && i < 4000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 4000) begin
      n_fail++;
      end_sim;
    end
    #1;
  endtask
  task automatic restart;
    @(posedge clk) enable_in <= 1'h0;
    wt(10);
    @(posedge clk) enable_in <= 1'h1;
    wpg;
    chk("pwm", pwm_out & pwm_oe, 4'h7);
  endtask
  task automatic shut(input string nm);
    chk({nm, " pwm_oe"}, {nb_pwm_oe, pwm_oe}, 5'h00);
    chk({nm, " pg"}, power_good_out, 1'h0);
    chk({nm, " drv"}, {driver_enable_in, nb_driver_enable_in}, 2'h0);
    chk({nm, " drv out"}, {driver_enable_out, nb_driver_enable_out}, 2'h0);
  endtask
  task automatic ovp(input int n);
    repeat (n) begin
      @(posedge clk) ov_cmp_in <= 1'h1;
      wt(6);
      @(posedge clk) ov_cmp_in <= 1'h0;
      wt(30);
    end
  endtask
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge clk) pwm_osc_in <= 1'h1;
      wt(2);
      @(posedge clk) pwm_osc_in <= 1'h0;
      wt(2);
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    #1;
    chk("phase_count", phase_count, 2'h3);
    @(posedge clk) rst_n <= 1'h1;
    wt(1);
    shut("reset");
    bus(1'h0, 4'hc, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'h1, 4'h8, 32'hffff_ffff);
    bus(1'h0, 4'h8, 32'h0);
    chk("mask", q, 32'h3f);
    @(posedge clk) supply5_ok_in <= 1'h1;
    supply12_ok_in <= 1'h1;
    enable_in <= 1'h1;
    wpg;
    chk("levels", {core_level, nb_level}, 14'h0102);
    chk("pwm", pwm_out & pwm_oe, 4'h7);
    @(posedge clk) pwm_in <= 4'h5;
    wt(2);
    chk("pwm pass", {nb_pwm_out, pwm_out & pwm_oe}, 5'h15);
    @(posedge clk) pwm_in <= 4'hf;
    @(posedge clk) cpu_power_ok_in <= 1'h1;
    wt(10);
    @(posedge clk) vid_code_in <= 7'h78;
    wt(600);
    chk("core", core_level, 7'h04);
    @(posedge clk) cpu_power_ok_in <= 1'h0;
    wt(600);
    chk("core pg", {core_level, power_good_out}, 8'h05);
    done("startup");
    @(posedge clk) ov_cmp_in <= 1'h1;
    wt(8);
    chk("ov", {pwm_out & pwm_oe, power_good_out, driver_enable_oe, irq}, 7'h01);
    chk("ov nb pwm", nb_pwm_out, 1'h0);
    @(posedge clk) ov_cmp_in <= 1'h0;
    wt(40);
    chk("ov end", {pwm_out & pwm_oe, power_good_out}, 5'h0f);
    bus(1'h0, 4'h0, 32'h0);
    chk("ov_count", q[12:8], 5'h01);
    bus(1'h1, 4'h8, 32'h0);
    wt(2);
    chk("irq masked", irq, 1'h0);
    bus(1'h1, 4'h8, 32'h3f);
    bus(1'h1, 4'h4, 32'h3f);
    wt(2);
    chk("irq cleared", irq, 1'h0);
    ovp(3);
    chk("ov latch pwm", pwm_out & pwm_oe, 4'h0);
    bus(1'h0, 4'h0, 32'h0);
    chk("ov latch", q[4], 1'h1);
    @(posedge clk) phase_sel_in <= 2'h2;
    restart;
    bus(1'h0, 4'h0, 32'h0);
    chk("ov_count", q[12:8], 5'h00);
    ovp(2);
    osc(8);
    wt(4);
    bus(1'h0, 4'h0, 32'h0);
    chk("ov_count", q[12:8], 5'h01);
    osc(16);
    wt(4);
    bus(1'h0, 4'h0, 32'h0);
    chk("ov_count", q[12:8], 5'h00);
    done("overvoltage");
    @(posedge clk) uv_cmp_in <= 1'h1;
    wt(8);
    chk("uv", {pwm_out & pwm_oe, power_good_out, driver_enable_oe}, 6'h1c);
    bus(1'h0, 4'h4, 32'h0);
    chk("uv event", q[3], 1'h1);
    @(posedge clk) uv_cmp_in <= 1'h0;
    wpg;
    for (k = 0; k < 2; k++) begin
      @(posedge clk) ext_low[k] <= 1'h1;
      wt(8);
      chk("ext pg", power_good_out, 1'h0);
      chk("ext pullup", k ? nb_driver_enable_pullup : driver_enable_pullup, 1'h1);
      chk("ext level", k ? nb_level : core_level, 7'h00);
      @(posedge clk) ext_low[k] <= 1'h0;
      wt(4);
      bus(1'h0, 4'h0, 32'h0);
      chk("ext state", q[1:0], 2'h1);
      wpg;
    end
    done("monitor");
    @(posedge clk) oc_delayed_in <= 1'h1;
    wt(60);
    @(posedge clk) oc_delayed_in <= 1'h0;
    wt(10);
    chk("oc short", pwm_out & pwm_oe, 4'h7);
    @(posedge clk) oc_delayed_in <= 1'h1;
    wt(110);
    shut("oc delayed");
    bus(1'h0, 4'h4, 32'h0);
    chk("oc event", q[2], 1'h1);
    @(posedge clk) oc_delayed_in <= 1'h0;
    wt(20);
    shut("oc hold");
    restart;
    @(posedge clk) oc_immediate_in <= 1'h1;
    wt(5);
    shut("oc now");
    @(posedge clk) oc_immediate_in <= 1'h0;
    restart;
    @(posedge clk) nb_oc_in <= 1'h1;
    wt(5);
    chk("nb drv", nb_driver_enable_in, 1'h0);
    @(posedge clk) nb_oc_in <= 1'h0;
    @(posedge clk) supply5_ok_in <= 1'h0;
    @(posedge clk) phase_sel_in <= 2'h3;
    serial_id_mode <= 1'h0;
    wt(8);
    shut("lockout");
    @(posedge clk) supply5_ok_in <= 1'h1;
    wpg;
    chk("pwm", pwm_out & pwm_oe, 4'hf);
    chk("nb parallel", nb_level, 7'h00);
    done("overcurrent");
    end_sim;
  end
endmodule
